//--- src/tsm_settings_menu.v
// keypad settings menu, correction arithmetic and output scaling of a thermometer
// assumes level keys synchronous to core_clk_i and an AXI4-Lite master
// What this block does
// - menu key held 2 s while measuring enters configuration at item zero.
// - in configuration each menu press advances to the next adjustable item.
// - up steps the selected value higher, down steps it lower.
// - quit stores all settings and returns to measuring.
// - unit picks Celsius or Fahrenheit for every temperature shown or taken.
// - resolution is tenth, hundredth or automatic.
// - automatic mode picks resolution itself; it is the default.
// - offset spans +-2.50 C or +-4.50 F; off means zero.
// - shown temperature is measured temperature minus offset.
// - offset indicator lights when offset is not off.
// - scale correction spans +-2.000 percent; off is zero and default.
// - Celsius reading is multiplied by one plus scale over 100.
// - Fahrenheit: subtract 32, apply scale factor, add 32 back.
// - correction indicator lights when scale correction is not off.
// - power-off delay 1 to 120 minutes without keys or traffic.
// - power-off set to off never switches the device off.
// - output is disabled, serial interface or 0..1 V analogue.
// - serial base address takes only 01, 11, ... 91.
// - zero-volt point spans -200.0..850.0 C or -328.0..1562.0 F.
// - one-volt point spans the same range in the selected unit.
// - set and store held over 2 s restore factory defaults.
// - above one-volt point gives full scale, below zero-volt gives zero.
// - values read over the interface are in the selected unit.
`include "tsm_defs.vh"
`default_nettype none
module tsm_settings_menu #(
    parameter HOLD_CYCLES = `TSM_HOLD_MS * (`TSM_CLK_HZ / 1000),
    parameter MIN_CYCLES  = `TSM_MIN_S * `TSM_CLK_HZ,
    parameter DAC_W       = 16
) (
    input  wire               core_clk_i,
    input  wire               rst_i,
    input  wire               key_menu_i,
    input  wire               key_up_i,
    input  wire               key_down_i,
    input  wire               key_quit_i,
    input  wire               if_activity_i,
    input  wire [19:0]        meas_temp_i,
    input  wire               s_axi_awvalid_i,
    output reg                s_axi_awready_o,
    input  wire [7:0]         s_axi_awaddr_i,
    input  wire               s_axi_wvalid_i,
    output reg                s_axi_wready_o,
    input  wire [31:0]        s_axi_wdata_i,
    input  wire [3:0]         s_axi_wstrb_i,
    output reg                s_axi_bvalid_o,
    input  wire               s_axi_bready_i,
    output reg  [1:0]         s_axi_bresp_o,
    input  wire               s_axi_arvalid_i,
    output reg                s_axi_arready_o,
    input  wire [7:0]         s_axi_araddr_i,
    output reg                s_axi_rvalid_o,
    input  wire               s_axi_rready_i,
    output reg  [31:0]        s_axi_rdata_o,
    output reg  [1:0]         s_axi_rresp_o,
    output reg                config_o,
    output reg  [3:0]         item_o,
    output reg  [31:0]        item_value_o,
    output reg  [31:0]        disp_temp_o,
    output reg                unit_f_o,
    output reg                res_fine_o,
    output reg                offset_ind_o,
    output reg                corr_ind_o,
    output reg                commit_o,
    output reg                power_off_o,
    output reg                serial_en_o,
    output reg                dac_en_o,
    output reg  [6:0]         base_addr_o,
    output reg  [DAC_W-1:0]   dac_code_o
);
    localparam [63:0] FULL = (64'h1 << DAC_W) - 64'h1;

    reg               unit;
    reg [1:0]         res;
    reg [1:0]         outf;
    reg [3:0]         adr;
    reg [7:0]         pwr;
    reg signed [31:0] offs;
    reg signed [31:0] scal;
    reg signed [31:0] dac0;
    reg signed [31:0] dac1;
    reg [3:0]         prev;
    reg [31:0]        hold_cnt;
    reg [31:0]        rst_cnt;
    reg               rst_done;
    reg [31:0]        cyc_cnt;
    reg [7:0]         min_cnt;
    reg               aw_held;
    reg               w_held;
    reg [7:0]         aw_addr;
    reg [31:0]        w_data;
    reg [3:0]         w_strb;

    function signed [31:0] lim;
        input signed [31:0] v;
        input signed [31:0] lo;
        input signed [31:0] hi;
        begin
            lim = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    // key edges; rows are menu, up, down, quit
    wire [3:0] keys = {key_quit_i, key_down_i, key_up_i, key_menu_i};
    wire [3:0] rise = keys & ~prev;
    wire       both = key_menu_i & key_quit_i;
    wire       restore_key = both && !rst_done && rst_cnt == HOLD_CYCLES;
    wire       enter_cfg = !config_o && key_menu_i && !key_quit_i
                           && hold_cnt == HOLD_CYCLES - 1;
    wire       step_up = config_o && rise[1] && !key_down_i;
    wire       step_dn = config_o && rise[2] && !key_up_i;

    // selected item: value and its limits in the present unit
    reg signed [31:0] cur;
    reg signed [31:0] lo;
    reg signed [31:0] hi;
    always @* begin
        cur = 32'sd0;
        lo  = 32'sd0;
        hi  = 32'sd0;
        case (item_o)
            4'd0: begin cur = {31'h0, unit}; hi = 32'sd1; end
            4'd1: begin cur = {30'h0, res}; hi = 32'sd2; end
            4'd2: begin
                cur = offs;
                hi  = unit ? `TSM_OFFS_F : `TSM_OFFS_C;
                lo  = -hi;
            end
            4'd3: begin cur = scal; hi = `TSM_SCAL_MAX; lo = -hi; end
            4'd4: begin cur = {24'h0, pwr}; hi = `TSM_PWR_MAX; end
            4'd5: begin cur = {30'h0, outf}; hi = 32'sd2; end
            4'd6: begin cur = {28'h0, adr}; hi = `TSM_ADR_MAX; end
            4'd7, 4'd8: begin
                cur = (item_o == 4'd7) ? dac0 : dac1;
                lo  = unit ? `TSM_DAC_F_LO : `TSM_DAC_C_LO;
                hi  = unit ? `TSM_DAC_F_HI : `TSM_DAC_C_HI;
            end
            default: cur = 32'sd0;
        endcase
    end
    wire signed [31:0] stepped = lim(cur + (step_up ? 32'sd1 : -32'sd1), lo, hi);

    // next adjustable item; address and set points only where output uses them
    reg [3:0] next_item;
    always @* begin
        case (item_o)
            4'd5:    next_item = (outf == `TSM_OUT_SER) ? 4'd6 :
                                 ((outf == `TSM_OUT_DAC) ? 4'd7 : 4'd0);
            4'd6:    next_item = 4'd0;
            4'd8:    next_item = 4'd0;
            default: next_item = item_o + 4'd1;
        endcase
    end

    // register reads and byte-lane merge for writes
    wire [31:0] cfg_word = ({31'h0, unit} << `TSM_S_UNIT) | ({30'h0, res} << `TSM_S_RES)
                         | ({30'h0, outf} << `TSM_S_OUT) | ({28'h0, adr} << `TSM_S_ADR)
                         | ({24'h0, pwr} << `TSM_S_PWR);
    wire [31:0] stat_word = ({31'h0, config_o} << `TSM_S_CFGM)
                          | ({28'h0, item_o} << `TSM_S_ITEM)
                          | ({31'h0, offset_ind_o} << `TSM_S_OFFI)
                          | ({31'h0, corr_ind_o} << `TSM_S_CORI)
                          | ({31'h0, res_fine_o} << `TSM_S_FINE)
                          | ({31'h0, power_off_o} << `TSM_S_POFF);
    function [32:0] rd;       // bit 32 flags an unmapped address
        input [7:0] a;
        begin
            case (a)
                `TSM_A_STAT: rd = {1'b0, stat_word};
                `TSM_A_DISP: rd = {1'b0, disp_temp_o};
                `TSM_A_CFG:  rd = {1'b0, cfg_word};
                `TSM_A_OFFS: rd = {1'b0, offs};
                `TSM_A_SCAL: rd = {1'b0, scal};
                `TSM_A_DAC0: rd = {1'b0, dac0};
                `TSM_A_DAC1: rd = {1'b0, dac1};
                `TSM_A_CMD:  rd = 33'h0;
                default:     rd = {1'b1, 32'h0};
            endcase
        end
    endfunction
    wire [32:0] wr_old = rd(aw_addr);
    wire [31:0] wmask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] wv     = (wr_old[31:0] & ~wmask) | (w_data & wmask);
    wire        wr_go  = aw_held && w_held && !s_axi_bvalid_o;
    wire        cmd_wr = wr_go && aw_addr == `TSM_A_CMD;
    wire        bus_restore = cmd_wr && wv[`TSM_S_RESTORE];
    wire        restore = restore_key || bus_restore;
    wire signed [31:0] wr_res  = lim({30'h0, wv[`TSM_S_RES+1:`TSM_S_RES]}, 0, 2);
    wire signed [31:0] wr_outf = lim({30'h0, wv[`TSM_S_OUT+1:`TSM_S_OUT]}, 0, 2);
    wire signed [31:0] wr_adr  = lim({28'h0, wv[`TSM_S_ADR+3:`TSM_S_ADR]}, 0, `TSM_ADR_MAX);
    wire signed [31:0] wr_pwr  = lim({24'h0, wv[`TSM_S_PWR+7:`TSM_S_PWR]}, 0, `TSM_PWR_MAX);
    // menu state
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            config_o <= 1'b0;
            item_o   <= 4'd0;
            hold_cnt <= 32'h0;
            rst_cnt  <= 32'h0;
            rst_done <= 1'b0;
            prev     <= 4'h0;
            commit_o <= 1'b0;
        end else begin
            prev     <= keys;
            hold_cnt <= (!config_o && key_menu_i && !key_quit_i) ? hold_cnt + 32'h1 : 32'h0;
            // counts past the limit once so "more than" holds
            rst_cnt  <= (both && rst_cnt != HOLD_CYCLES) ? rst_cnt + 32'h1 :
                        (both ? rst_cnt : 32'h0);
            rst_done <= both && (rst_done || restore_key);
            commit_o <= (config_o && rise[3]) || restore
                        || (cmd_wr && wv[`TSM_S_COMMIT]);
            if (enter_cfg) begin
                config_o <= 1'b1;
                item_o   <= 4'd0;
            end else if (config_o && rise[3]) begin
                config_o <= 1'b0;
            end else if (config_o && rise[0]) begin
                item_o   <= next_item;
            end
        end
    end
    // settings: restore beats bus write beats keys
    always @(posedge core_clk_i) begin
        if (rst_i || restore) begin
            unit <= `TSM_R_UNIT;
            res  <= `TSM_R_RES;
            outf <= `TSM_R_OUT;
            adr  <= `TSM_R_ADR;
            pwr  <= `TSM_R_PWR;
            offs <= 32'sd0;
            scal <= 32'sd0;
            dac0 <= 32'sd0;
            dac1 <= `TSM_R_DAC1;
        end else if (wr_go) begin
            case (aw_addr)
                `TSM_A_CFG: begin
                    unit <= wv[`TSM_S_UNIT];
                    res  <= wr_res[1:0];
                    outf <= wr_outf[1:0];
                    adr  <= wr_adr[3:0];
                    pwr  <= wr_pwr[7:0];
                end
                `TSM_A_OFFS: offs <= lim(wv, unit ? -`TSM_OFFS_F : -`TSM_OFFS_C,
                                         unit ? `TSM_OFFS_F : `TSM_OFFS_C);
                `TSM_A_SCAL: scal <= lim(wv, -`TSM_SCAL_MAX, `TSM_SCAL_MAX);
                `TSM_A_DAC0: dac0 <= lim(wv, unit ? `TSM_DAC_F_LO : `TSM_DAC_C_LO,
                                         unit ? `TSM_DAC_F_HI : `TSM_DAC_C_HI);
                `TSM_A_DAC1: dac1 <= lim(wv, unit ? `TSM_DAC_F_LO : `TSM_DAC_C_LO,
                                         unit ? `TSM_DAC_F_HI : `TSM_DAC_C_HI);
                default: ;
            endcase
        end else if (step_up || step_dn) begin
            case (item_o)
                4'd0: if (stepped[0] != unit) begin
                    // stored temperatures follow the unit so their meaning holds
                    unit <= stepped[0];
                    offs <= stepped[0] ? lim(offs * 9 / 5, -`TSM_OFFS_F, `TSM_OFFS_F)
                                       : lim(offs * 5 / 9, -`TSM_OFFS_C, `TSM_OFFS_C);
                    dac0 <= stepped[0] ?
                        lim(dac0 * 9 / 5 + `TSM_F_BASE10, `TSM_DAC_F_LO, `TSM_DAC_F_HI) :
                        lim((dac0 - `TSM_F_BASE10) * 5 / 9, `TSM_DAC_C_LO, `TSM_DAC_C_HI);
                    dac1 <= stepped[0] ?
                        lim(dac1 * 9 / 5 + `TSM_F_BASE10, `TSM_DAC_F_LO, `TSM_DAC_F_HI) :
                        lim((dac1 - `TSM_F_BASE10) * 5 / 9, `TSM_DAC_C_LO, `TSM_DAC_C_HI);
                end
                4'd1: res  <= stepped[1:0];
                4'd2: offs <= stepped;
                4'd3: scal <= stepped;
                4'd4: pwr  <= stepped[7:0];
                4'd5: outf <= stepped[1:0];
                4'd6: adr  <= stepped[3:0];
                4'd7: dac0 <= stepped;
                4'd8: dac1 <= stepped;
                default: ;
            endcase
        end
    end
    // correction arithmetic in the selected unit, hundredths of a degree
    wire signed [31:0] m_c  = {{12{meas_temp_i[19]}}, meas_temp_i};
    wire signed [31:0] base = unit ? `TSM_F_BASE : 32'sd0;
    wire signed [31:0] m_u  = unit ? m_c * 9 / 5 + base : m_c;
    wire signed [31:0] d    = m_u - offs - base;
    wire signed [31:0] t_s  = d + d * scal / `TSM_SCAL_DIV + base;
    wire signed [31:0] t_ab = (t_s < 0) ? -t_s : t_s;
    // hysteresis keeps auto mode from chattering at the threshold
    wire fine_nx = (res == `TSM_RES_HUND) ? 1'b1 :
                   (res == `TSM_RES_TENTH) ? 1'b0 :
                   (res_fine_o ? (t_ab < `TSM_AUTO_HI) : (t_ab < `TSM_AUTO_LO));
    // analogue output; set points are tenths, reading is hundredths
    wire signed [31:0] z    = dac0 * 10;
    wire signed [31:0] f    = dac1 * 10;
    wire [31:0]        dt   = t_s - z;
    wire [31:0]        span = f - z;
    wire [63:0]        q    = ({32'h0, dt} * FULL) / {32'h0, span};
    wire [DAC_W-1:0]   dac_nx = (outf != `TSM_OUT_DAC) ? {DAC_W{1'b0}} :
                                (t_s < z) ? {DAC_W{1'b0}} :
                                (t_s >= f) ? FULL[DAC_W-1:0] : q[DAC_W-1:0];

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            disp_temp_o  <= 32'h0;
            res_fine_o   <= 1'b0;
            offset_ind_o <= 1'b0;
            corr_ind_o   <= 1'b0;
            unit_f_o     <= 1'b0;
            item_value_o <= 32'h0;
            serial_en_o  <= 1'b0;
            dac_en_o     <= 1'b0;
            base_addr_o  <= 7'h0;
            dac_code_o   <= {DAC_W{1'b0}};
        end else begin
            disp_temp_o  <= fine_nx ? t_s : (t_s / 10) * 10;
            res_fine_o   <= fine_nx;
            offset_ind_o <= offs != 0;
            corr_ind_o   <= scal != 0;
            unit_f_o     <= unit;
            item_value_o <= (item_o == 4'd6) ? {25'h0, adr, 3'h0} + {26'h0, adr, 1'b0}
                            + 32'h1 : cur;
            serial_en_o  <= outf == `TSM_OUT_SER;
            dac_en_o     <= outf == `TSM_OUT_DAC;
            base_addr_o  <= {adr, 3'h0} + {2'h0, adr, 1'b0} + 7'h1;
            dac_code_o   <= dac_nx;
        end
    end

    // auto power-off; any key press edge or link traffic restarts the count
    wire activity = (|rise) || if_activity_i || wr_go
                    || (s_axi_arvalid_i && s_axi_arready_o);
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cyc_cnt     <= 32'h0;
            min_cnt     <= 8'h0;
            power_off_o <= 1'b0;
        end else if (activity || pwr == 8'h0) begin
            cyc_cnt <= 32'h0;
            min_cnt <= 8'h0;
        end else if (cyc_cnt == MIN_CYCLES - 1) begin
            cyc_cnt <= 32'h0;
            min_cnt <= min_cnt + 8'h1;
            if (min_cnt + 8'h1 >= pwr)
                power_off_o <= 1'b1;
        end else begin
            cyc_cnt <= cyc_cnt + 32'h1;
        end
    end

    // AXI4-Lite slave: address and data taken in either order
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= 2'h0;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0;
            s_axi_rresp_o   <= 2'h0;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end else begin
            s_axi_awready_o <= !aw_held && !(s_axi_awvalid_i && s_axi_awready_o)
                               && !s_axi_bvalid_o;
            s_axi_wready_o  <= !w_held && !(s_axi_wvalid_i && s_axi_wready_o)
                               && !s_axi_bvalid_o;
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_old[32] ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_rvalid_o <= 1'b1;
                {s_axi_rresp_o[1], s_axi_rdata_o} <= rd(s_axi_araddr_i);
                s_axi_rresp_o[0] <= 1'b0;
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end
endmodule // tsm_settings_menu
`default_nettype wire

//--- src/tsm_defs.vh
// constants of the thermometer settings menu: offsets, fields, defaults, limits
// assumes temperatures in hundredths of a degree, set points in tenths
`ifndef TSM_DEFS_VH
`define TSM_DEFS_VH
`define TSM_CLK_HZ 20000000
`define TSM_HOLD_MS 2000
`define TSM_MIN_S 60
`define TSM_A_STAT 8'h00
`define TSM_A_DISP 8'h04
`define TSM_A_CFG 8'h08
`define TSM_A_OFFS 8'h0c
`define TSM_A_SCAL 8'h10
`define TSM_A_DAC0 8'h14
`define TSM_A_DAC1 8'h18
`define TSM_A_CMD 8'h1c
`define TSM_S_UNIT 0
`define TSM_S_RES 1
`define TSM_S_OUT 4
`define TSM_S_ADR 8
`define TSM_S_PWR 16
`define TSM_S_CFGM 0
`define TSM_S_ITEM 4
`define TSM_S_OFFI 8
`define TSM_S_CORI 9
`define TSM_S_FINE 10
`define TSM_S_POFF 11
`define TSM_S_RESTORE 0
`define TSM_S_COMMIT 1
`define TSM_R_UNIT 1'b0
`define TSM_R_RES 2'h2
`define TSM_R_OUT 2'h0
`define TSM_R_ADR 4'h0
`define TSM_R_PWR 8'h00
`define TSM_R_DAC1 1000
`define TSM_RES_TENTH 2'h0
`define TSM_RES_HUND 2'h1
`define TSM_RES_AUTO 2'h2
`define TSM_OUT_OFF 2'h0
`define TSM_OUT_SER 2'h1
`define TSM_OUT_DAC 2'h2
`define TSM_OFFS_C 250
`define TSM_OFFS_F 450
`define TSM_SCAL_MAX 2000
`define TSM_SCAL_DIV 100000
`define TSM_PWR_MAX 120
`define TSM_ADR_MAX 9
`define TSM_DAC_C_LO (-2000)
`define TSM_DAC_C_HI 8500
`define TSM_DAC_F_LO (-3280)
`define TSM_DAC_F_HI 15620
`define TSM_F_BASE 3200
`define TSM_F_BASE10 320
`define TSM_AUTO_HI 10000
`define TSM_AUTO_LO 9900
`endif

//--- tb/tsm_checker.sv
// port checker of the settings menu: key handling, commit pulse, outputs
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
module tsm_checker (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic        key_menu_i,
    input wire logic        key_quit_i,
    input wire logic        if_activity_i,
    input wire logic        config_o,
    input wire logic [3:0]  item_o,
    input wire logic [31:0] disp_temp_o,
    input wire logic        res_fine_o,
    input wire logic        commit_o,
    input wire logic        power_off_o,
    input wire logic        serial_en_o,
    input wire logic        dac_en_o,
    input wire logic [6:0]  base_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    AST_ENTRY: assert property ($rose(config_o) |-> item_o == 4'h0 && $past(key_menu_i, 8))
        else $error("config entered without long menu hold");
    AST_ITEM: assert property (item_o <= 4'h8)
        else $error("item out of range");
    AST_QUIT: assert property (config_o && $rose(key_quit_i) && !key_menu_i |-> ##[1:2] commit_o)
        else $error("quit gave no commit");
    AST_LEAVE: assert property (config_o && $rose(key_quit_i) && !key_menu_i |-> ##[1:3] !config_o)
        else $error("quit did not leave config");
    AST_PULSE: assert property (commit_o |=> !commit_o)
        else $error("commit longer than one cycle");
    AST_COARSE: assert property (!res_fine_o |-> $signed(disp_temp_o) % 10 == 0)
        else $error("coarse reading has hundredths");
    AST_PWR_HOLD: assert property (power_off_o |=> power_off_o)
        else $error("power off not kept");
    AST_PWR_QUIET: assert property ($rose(power_off_o) |-> !$past(if_activity_i))
        else $error("power off during traffic");
    AST_OUT_ONE: assert property (!(serial_en_o && dac_en_o))
        else $error("two output functions at once");
    AST_ADR: assert property (serial_en_o |-> base_addr_o % 10 == 1 && base_addr_o <= 7'd91)
        else $error("bad base address");
endmodule // tsm_checker
bind tsm_settings_menu tsm_checker chk_i (.*);
`default_nettype wire

//--- tb/tsm_keypad_model.sv
// keypad model: holds a key combination for a number of clock edges
// assumes press() is called from one process only
`default_nettype none
module tsm_keypad_model (
    input wire logic core_clk_i,
    output logic     key_menu_o,
    output logic     key_up_o,
    output logic     key_down_o,
    output logic     key_quit_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {key_menu_o, key_up_o, key_down_o, key_quit_o} = 4'h0;
    // k is {menu, up, down, quit}; gap after release so edges are seen apart
    task automatic press(input logic [3:0] k, input int n);
        @(posedge core_clk_i);
        {key_menu_o, key_up_o, key_down_o, key_quit_o} <= k;
        repeat (n) @(posedge core_clk_i);
        {key_menu_o, key_up_o, key_down_o, key_quit_o} <= 4'h0;
        repeat (3) @(posedge core_clk_i);
    endtask
endmodule // tsm_keypad_model
`default_nettype wire

//--- tb/tb_tsm_settings_menu.sv
// bench of the settings menu: bus tasks, key presses, display checks
// assumes holds of 20 cycles and minutes of 10 cycles
`include "tsm_defs.vh"
`default_nettype none
module tb_tsm_settings_menu;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 0, rst_i = 1, if_activity_i = 0;
    logic key_menu_i, key_up_i, key_down_i, key_quit_i;
    logic [19:0] meas_temp_i = 20'h0;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, item_value_o, disp_temp_o, rdat;
    logic [3:0] s_axi_wstrb_i = 4'hf, item_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic config_o, unit_f_o, res_fine_o, offset_ind_o, corr_ind_o, commit_o;
    logic power_off_o, serial_en_o, dac_en_o;
    logic [6:0] base_addr_o;
    logic [15:0] dac_code_o;
    int miscompares = 0, n_tests = 0, cyc = 0, commits = 0;
    tsm_settings_menu #(.HOLD_CYCLES(20), .MIN_CYCLES(10), .DAC_W(16)) dut (.*);
    tsm_keypad_model kp (.core_clk_i(core_clk_i), .key_menu_o(key_menu_i),
        .key_up_o(key_up_i), .key_down_o(key_down_i), .key_quit_o(key_quit_i));
    always #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (commit_o === 1'b1) commits <= commits + 1;
        if (cyc == 8000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic nap(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // bready held from the start; each channel dropped at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 0;
        @(posedge core_clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1;
        s_axi_wvalid_i <= 1;
        s_axi_bready_i <= 1;
        while (!b) begin
            @(negedge core_clk_i);
            aw = s_axi_awvalid_i & s_axi_awready_o;
            w = s_axi_wvalid_i & s_axi_wready_o;
            b = s_axi_bvalid_o === 1'b1;
            resp = s_axi_bresp_o;
            @(posedge core_clk_i);
            if (aw) s_axi_awvalid_i <= 0;
            if (w) s_axi_wvalid_i <= 0;
            if (b) s_axi_bready_i <= 0;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        logic ar, r;
        r = 0;
        @(posedge core_clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1;
        s_axi_rready_i <= 1;
        while (!r) begin
            @(negedge core_clk_i);
            ar = s_axi_arvalid_i & s_axi_arready_o;
            r = s_axi_rvalid_o === 1'b1;
            rdat = s_axi_rdata_o;
            resp = s_axi_rresp_o;
            @(posedge core_clk_i);
            if (ar) s_axi_arvalid_i <= 0;
            if (r) s_axi_rready_i <= 0;
        end
    endtask
    initial begin
        nap(6);
        rst_i <= 0;
        rd(`TSM_A_CFG);
        chk("cfg", 32'h4, rdat);
        rd(`TSM_A_SCAL);
        chk("scale", 32'h0, rdat);
        rd(8'h20);
        chk("resp", 32'h2, {30'h0, resp});
        kp.press(4'h8, 10);
        chk("config", 32'h0, {31'h0, config_o});
        kp.press(4'h8, 25);
        chk("config", 32'h1, {31'h0, config_o});
        kp.press(4'h8, 2);
        chk("item", 32'h1, {28'h0, item_o});
        kp.press(4'h4, 2);
        chk("value", 32'h2, item_value_o);
        kp.press(4'h2, 2);
        chk("value", 32'h1, item_value_o);
        repeat (5) kp.press(4'h8, 2);
        chk("item", 32'h0, {28'h0, item_o});
        kp.press(4'h1, 2);
        chk("commits", 32'h1, commits);
        chk("config", 32'h0, {31'h0, config_o});
        rd(`TSM_A_CFG);
        chk("cfg", 32'h2, rdat);
        meas_temp_i <= 20'd2000;
        wr(`TSM_A_OFFS, 32'd100);
        nap(4);
        chk("disp", 32'd1900, disp_temp_o);
        chk("offset_ind", 32'h1, {31'h0, offset_ind_o});
        wr(`TSM_A_OFFS, 32'd999);
        rd(`TSM_A_OFFS);
        chk("offset", 32'd250, rdat);
        wr(`TSM_A_OFFS, 32'd0);
        wr(`TSM_A_SCAL, 32'd2000);
        nap(4);
        chk("disp", 32'd2040, disp_temp_o);
        chk("corr_ind", 32'h1, {31'h0, corr_ind_o});
        wr(`TSM_A_CFG, 32'h3);
        nap(4);
        chk("disp", 32'd6872, disp_temp_o);
        chk("unit_f", 32'h1, {31'h0, unit_f_o});
        wr(`TSM_A_CFG, 32'h310);
        nap(4);
        chk("base", 32'd31, {25'h0, base_addr_o});
        chk("serial", 32'h1, {31'h0, serial_en_o});
        wr(`TSM_A_DAC0, 32'hffff_f000);
        rd(`TSM_A_DAC0);
        chk("dac0", 32'hffff_f830, rdat);
        wr(`TSM_A_DAC0, 32'h0);
        wr(`TSM_A_CFG, 32'h20);
        meas_temp_i <= 20'd20000;
        nap(4);
        chk("dac", 32'hffff, {16'h0, dac_code_o});
        meas_temp_i <= 20'd5000;
        nap(4);
        chk("dac", 32'h828e, {16'h0, dac_code_o});
        meas_temp_i <= 20'hffc18;
        nap(4);
        chk("dac", 32'h0, {16'h0, dac_code_o});
        kp.press(4'h9, 25);
        rd(`TSM_A_CFG);
        chk("cfg", 32'h4, rdat);
        chk("fine", 32'h1, {31'h0, res_fine_o});
        nap(40);
        chk("poweroff", 32'h0, {31'h0, power_off_o});
        wr(`TSM_A_CFG, 32'h1_0004);
        if_activity_i <= 1;
        nap(30);
        chk("poweroff", 32'h0, {31'h0, power_off_o});
        if_activity_i <= 0;
        nap(40);
        chk("poweroff", 32'h1, {31'h0, power_off_o});
        finish_test();
    end
endmodule // tb_tsm_settings_menu
`default_nettype wire
